// ==== design/sml_pkg.sv ====
`default_nettype none
package sml_pkg;
    // --------------------------------------------------------------
    // Clock and strap settle timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 10;
    localparam int STRAP_SETTLE_NS = 1000;
    localparam int STRAP_SETTLE_CYC =
        (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = 8;

    // --------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // --------------------------------------------------------------
    localparam logic [7:0] IDX_BRIDGE_CONTROL       = 8'h4F;
    localparam logic [7:0] IDX_BRIDGE_CONFIGURATION = 8'h54;
    localparam logic [7:0] IDX_LINK_PAIR_CONTROL    = 8'h5B;
    localparam logic [7:0] IDX_STRAP_STATUS         = 8'h60;
    localparam logic [7:0] IDX_FAR_ID_ADDR          = 8'h61;

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int BIT_DISPLAY_ID_OFF  = 0;
    localparam int BIT_AUX_AUDIO       = 1;
    localparam int BIT_FAR_ID_COPY     = 5;
    localparam int BIT_OUTSIDE_CONTROL = 7;
    localparam int BIT_CABLE_TYPE      = 7;
    localparam int BIT_STAT_DONE       = 7;

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [7:0] RST_BRIDGE_CONTROL       = 8'h00;
    localparam logic [7:0] RST_BRIDGE_CONFIGURATION = 8'h00;
    localparam logic [7:0] RST_LINK_PAIR_CONTROL    = 8'h00;
    localparam logic [7:0] RST_FAR_ID_ADDR          = 8'hA0;

    // --------------------------------------------------------------
    // AXI responses
    // --------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SML_WAIT  = 3'h1,
        SML_LATCH = 3'h2,
        SML_RUN   = 3'h4
    } sml_state_e;
endpackage
`default_nettype wire

// ==== design/sml_strap_decode.sv ====
`default_nettype none
module sml_strap_decode
    import sml_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [1:0] mode_sel0_level,
    input  wire logic [2:0] mode_sel1_level,
    output logic            stable,
    output logic [1:0]      sel0_code,
    output logic [2:0]      sel1_code
);
    logic [4:0] s1_reg;
    logic [4:0] s2_reg;
    logic [4:0] s3_reg;
    logic [4:0] held_reg;
    logic [4:0] held_next;
    logic       stab_reg;
    logic       stab_next;

    // --------------------------------------------------------------
    // Level codes settle when the last two stages agree
    // --------------------------------------------------------------
    always_comb begin
        held_next = held_reg;
        stab_next = 1'b0;
        if (s2_reg == s3_reg) begin
            held_next = s3_reg;
            stab_next = (held_reg == s3_reg);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg   <= 5'h00;
            s2_reg   <= 5'h00;
            s3_reg   <= 5'h00;
            held_reg <= 5'h00;
            stab_reg <= 1'b0;
        end else begin
            s1_reg   <= {mode_sel1_level, mode_sel0_level};
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            held_reg <= held_next;
            stab_reg <= stab_next;
        end
    end

    // Level index in rising voltage order equals the bit pattern
    assign stable    = stab_reg;
    assign sel0_code = held_reg[1:0];
    assign sel1_code = held_reg[4:2];
endmodule // sml_strap_decode
`default_nettype wire

// ==== design/sml_top.sv ====
// Chosen here: the AXI4-Lite register port.
`default_nettype none
module sml_top
    import sml_pkg::*;
#(
    parameter int SETTLE_CYC = STRAP_SETTLE_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [1:0]  mode_sel0_level,
    input  wire logic [2:0]  mode_sel1_level,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             display_id_local,
    output logic             aux_audio_enable,
    output logic             outside_control_enable,
    output logic             cable_type_select_link_enable,
    output logic             far_display_id_copy,
    output logic [7:0]       far_display_id_addr,
    output logic             strap_done
);
    import sml_pkg::*;

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [7:0] idx_of(input logic [11:0] a);
        return a[9:2];
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        logic [7:0] i;
        i = idx_of(a);
        return (a[11:10] == 2'h0) && (a[1:0] == 2'h0) &&
               (i == IDX_BRIDGE_CONTROL || i == IDX_BRIDGE_CONFIGURATION ||
                i == IDX_LINK_PAIR_CONTROL || i == IDX_STRAP_STATUS ||
                i == IDX_FAR_ID_ADDR);
    endfunction

    // --------------------------------------------------------------
    // Strap decode
    // --------------------------------------------------------------
    logic       strap_stable;
    logic [1:0] sel0_code;
    logic [2:0] sel1_code;

    sml_strap_decode u_dec (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .mode_sel0_level (mode_sel0_level),
        .mode_sel1_level (mode_sel1_level),
        .stable          (strap_stable),
        .sel0_code       (sel0_code),
        .sel1_code       (sel1_code)
    );

    // --------------------------------------------------------------
    // Power-up latch sequencer
    // --------------------------------------------------------------
    sml_state_e          st_reg;
    sml_state_e          st_next;
    logic [SETTLE_W-1:0] cnt_reg;
    logic [SETTLE_W-1:0] cnt_next;
    logic                latch_now;

    always_comb begin
        st_next   = st_reg;
        cnt_next  = cnt_reg;
        latch_now = 1'b0;
        case (st_reg)
            SML_WAIT: begin
                if (!strap_stable) begin
                    cnt_next = '0;
                end else if (cnt_reg >= SETTLE_W'(SETTLE_CYC - 1)) begin
                    st_next = SML_LATCH;
                end else begin
                    cnt_next = cnt_reg + SETTLE_W'(1);
                end
            end
            SML_LATCH: begin
                latch_now = 1'b1;
                st_next   = SML_RUN;
            end
            SML_RUN: begin
                st_next = SML_RUN;
            end
            default: begin
                st_next = SML_WAIT;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg  <= SML_WAIT;
            cnt_reg <= '0;
        end else begin
            st_reg  <= st_next;
            cnt_reg <= cnt_next;
        end
    end

    // --------------------------------------------------------------
    // AXI4-Lite write path
    // --------------------------------------------------------------
    logic        aw_have_reg, aw_have_next;
    logic        w_have_reg, w_have_next;
    logic [11:0] awaddr_reg, awaddr_next;
    logic [7:0]  wbyte_reg, wbyte_next;
    logic        wen_reg, wen_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        awready_reg, awready_next, wready_reg, wready_next;
    logic        do_write;

    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next  = w_have_reg;
        awaddr_next  = awaddr_reg;
        wbyte_next   = wbyte_reg;
        wen_next     = wen_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        do_write     = 1'b0;
        if (s_axi_awvalid && awready_reg) begin
            aw_have_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_have_next = 1'b1;
            wbyte_next  = s_axi_wdata[7:0];
            wen_next    = s_axi_wstrb[0];
        end
        if (aw_have_reg && w_have_reg) begin
            do_write     = mapped(awaddr_reg) && wen_reg;
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        awready_next = !aw_have_next && !bvalid_next;
        wready_next  = !w_have_next && !bvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awaddr_reg  <= 12'h000;
            wbyte_reg   <= 8'h00;
            wen_reg     <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg  <= w_have_next;
            awaddr_reg  <= awaddr_next;
            wbyte_reg   <= wbyte_next;
            wen_reg     <= wen_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            awready_reg <= awready_next;
            wready_reg  <= wready_next;
        end
    end

    // --------------------------------------------------------------
    // Configuration registers
    // --------------------------------------------------------------
    logic [7:0] ctl_reg, ctl_next;
    logic [7:0] cfg_reg, cfg_next;
    logic [7:0] lpc_reg, lpc_next;
    logic [7:0] far_reg, far_next;
    logic [2:0] sw_reg, sw_next;
    logic       done_reg, done_next;
    logic [7:0] widx;

    always_comb begin
        ctl_next  = ctl_reg;
        cfg_next  = cfg_reg;
        lpc_next  = lpc_reg;
        far_next  = far_reg;
        sw_next   = sw_reg;
        done_next = done_reg | latch_now;
        widx      = idx_of(awaddr_reg);
        if (latch_now) begin
            // Registers already written by software keep their value
            if (!sw_reg[0]) begin
                ctl_next[BIT_DISPLAY_ID_OFF] = sel0_code[1];
            end
            if (!sw_reg[1]) begin
                cfg_next[BIT_AUX_AUDIO]       = sel0_code[0];
                cfg_next[BIT_OUTSIDE_CONTROL] = sel1_code[2];
                cfg_next[BIT_FAR_ID_COPY]     = sel1_code[0];
            end
            if (!sw_reg[2]) begin
                lpc_next[BIT_CABLE_TYPE] = sel1_code[1];
            end
        end
        if (do_write) begin
            if (widx == IDX_BRIDGE_CONTROL) begin
                ctl_next   = wbyte_reg;
                sw_next[0] = 1'b1;
            end else if (widx == IDX_BRIDGE_CONFIGURATION) begin
                cfg_next   = wbyte_reg;
                sw_next[1] = 1'b1;
            end else if (widx == IDX_LINK_PAIR_CONTROL) begin
                lpc_next   = wbyte_reg;
                sw_next[2] = 1'b1;
            end else if (widx == IDX_FAR_ID_ADDR) begin
                far_next = wbyte_reg;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_reg  <= RST_BRIDGE_CONTROL;
            cfg_reg  <= RST_BRIDGE_CONFIGURATION;
            lpc_reg  <= RST_LINK_PAIR_CONTROL;
            far_reg  <= RST_FAR_ID_ADDR;
            sw_reg   <= 3'h0;
            done_reg <= 1'b0;
        end else begin
            ctl_reg  <= ctl_next;
            cfg_reg  <= cfg_next;
            lpc_reg  <= lpc_next;
            far_reg  <= far_next;
            sw_reg   <= sw_next;
            done_reg <= done_next;
        end
    end

    // --------------------------------------------------------------
    // AXI4-Lite read path
    // --------------------------------------------------------------
    logic        arready_reg, arready_next;
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;
    logic [7:0]  ridx;

    always_comb begin
        arready_next = !rvalid_reg && !arready_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        ridx         = idx_of(s_axi_araddr);
        if (s_axi_arvalid && arready_reg) begin
            arready_next = 1'b0;
            rvalid_next  = 1'b1;
            rresp_next   = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_next   = 32'h0000_0000;
            if (!mapped(s_axi_araddr)) begin
                rdata_next = 32'h0000_0000;
            end else if (ridx == IDX_BRIDGE_CONTROL) begin
                rdata_next[7:0] = ctl_reg;
            end else if (ridx == IDX_BRIDGE_CONFIGURATION) begin
                rdata_next[7:0] = cfg_reg;
            end else if (ridx == IDX_LINK_PAIR_CONTROL) begin
                rdata_next[7:0] = lpc_reg;
            end else if (ridx == IDX_STRAP_STATUS) begin
                rdata_next[7:0] = {done_reg, 2'h0, sel1_code, sel0_code};
            end else if (ridx == IDX_FAR_ID_ADDR) begin
                rdata_next[7:0] = far_reg;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= RESP_OKAY;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    assign display_id_local       = ctl_reg[BIT_DISPLAY_ID_OFF];
    assign aux_audio_enable       = cfg_reg[BIT_AUX_AUDIO];
    assign outside_control_enable = cfg_reg[BIT_OUTSIDE_CONTROL];
    assign cable_type_select_link_enable       = lpc_reg[BIT_CABLE_TYPE];
    assign far_display_id_copy    = cfg_reg[BIT_FAR_ID_COPY];
    assign far_display_id_addr    = far_reg;
    assign strap_done             = done_reg;
endmodule // sml_top
`default_nettype wire

// ==== tb/sml_strap_board.sv ====
`default_nettype none
module sml_strap_board (
    input  wire logic [2:0] sel0_row,
    input  wire logic [3:0] sel1_row,
    output logic [1:0]      mode_sel0_level,
    output logic [2:0]      mode_sel1_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Divider rows count from 1 in rising ratio order
    assign mode_sel0_level = 2'(sel0_row - 3'h1);
    assign mode_sel1_level = 3'(sel1_row - 4'h1);
endmodule // sml_strap_board
`default_nettype wire

// ==== tb/sml_assertions.sv ====
`default_nettype none
module sml_assertions #(
    parameter int SETTLE_CYC = 2
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [1:0]  mode_sel0_level,
    input wire logic [2:0]  mode_sel1_level,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        display_id_local,
    input wire logic        aux_audio_enable,
    input wire logic        outside_control_enable,
    input wire logic        far_display_id_copy,
    input wire logic [7:0]  far_display_id_addr,
    input wire logic        strap_done
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DONE_MAX = SETTLE_CYC + 40;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_done_sticky: assert property (strap_done |=> strap_done)
        else $error("strap_done dropped");
    a_done_timely: assert property ($rose(aresetn) |->
        ##[1:DONE_MAX] strap_done)
        else $error("strap latch late");
    a_quiet_early: assert property (!strap_done |-> !display_id_local
        && !aux_audio_enable && !outside_control_enable
        && !far_display_id_copy)
        else $error("setting before latch");
    a_sel0_latch: assert property ($rose(strap_done) |->
        {display_id_local, aux_audio_enable} == mode_sel0_level)
        else $error("first strap decode wrong");
    a_sel1_latch: assert property ($rose(strap_done) |->
        {outside_control_enable, far_display_id_copy}
        == {mode_sel1_level[2], mode_sel1_level[0]})
        else $error("second strap decode wrong");
    a_far_addr_rst: assert property ($rose(aresetn) |->
        far_display_id_addr == 8'hA0)
        else $error("far id address reset wrong");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response timing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read response timing");
    a_busy_refuse: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready)
        else $error("accepting while response pending");
    a_rdata_byte: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 24'h0)
        else $error("read upper bits set");
endmodule // sml_assertions

bind sml_top sml_assertions #(.SETTLE_CYC(SETTLE_CYC)) sml_assertions_inst (
    .aclk, .aresetn, .mode_sel0_level, .mode_sel1_level, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .display_id_local, .aux_audio_enable, .outside_control_enable,
    .far_display_id_copy, .far_display_id_addr, .strap_done);
`default_nettype wire

// ==== tb/testbench.sv ====
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sml_pkg::*;
    localparam logic [11:0] A_CTL  = {2'h0, IDX_BRIDGE_CONTROL, 2'h0};
    localparam logic [11:0] A_CFG  = {2'h0, IDX_BRIDGE_CONFIGURATION, 2'h0};
    localparam logic [11:0] A_LINK = {2'h0, IDX_LINK_PAIR_CONTROL, 2'h0};
    localparam logic [11:0] A_STAT = {2'h0, IDX_STRAP_STATUS, 2'h0};
    localparam logic [11:0] A_FAR  = {2'h0, IDX_FAR_ID_ADDR, 2'h0};
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, strap_done;
    logic        display_id_local, aux_audio_enable, outside_control_enable;
    logic        cable_type_select_link_enable, far_display_id_copy;
    logic [2:0]  sel0_row, mode_sel1_level;
    logic [3:0]  sel1_row, s_axi_wstrb;
    logic [1:0]  mode_sel0_level, s_axi_bresp, s_axi_rresp;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [7:0]  far_display_id_addr;
    int          n_errors, total_checks;

    sml_strap_board sml_strap_board_inst (.sel0_row, .sel1_row,
        .mode_sel0_level, .mode_sel1_level);
    sml_top #(.SETTLE_CYC(4)) sml_top_inst (.aclk, .aresetn,
        .mode_sel0_level, .mode_sel1_level, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .display_id_local,
        .aux_audio_enable, .outside_control_enable, .cable_type_select_link_enable,
        .far_display_id_copy, .far_display_id_addr, .strap_done);

    // ------------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic axi_write(input logic [11:0] a, input logic [7:0] d,
                             input logic [3:0] st, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic do_reset(input logic [2:0] r0, input logic [3:0] r1);
        aresetn <= 1'h0;
        sel0_row <= r0;
        sel1_row <= r1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        while (strap_done !== 1'h1 && n < 80) begin
            @(posedge aclk);
            n++;
        end
        check(32'(strap_done), 32'h1, "latch done");
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_straps;
        logic [1:0]  s0, r;
        logic [2:0]  s1;
        logic [31:0] d;
        for (int i = 0; i < 8; i++) begin
            s0 = 2'(i);
            s1 = 3'(i);
            do_reset(3'(s0) + 3'h1, 4'(s1) + 4'h1);
            wait_done();
            check({display_id_local, aux_audio_enable}, s0,
                  "sel0");
            check({outside_control_enable, cable_type_select_link_enable,
                   far_display_id_copy}, s1, "sel1");
            axi_read(A_CTL, d, r);
            check(d, {31'h0, s0[1]}, "ctl read");
            axi_read(A_CFG, d, r);
            check(d, {24'h0, s1[2], 1'h0, s1[0], 3'h0, s0[0], 1'h0},
                  "cfg");
            axi_read(A_LINK, d, r);
            check(d, {24'h0, s1[1], 7'h0}, "link read");
            axi_read(A_STAT, d, r);
            check(d, {24'h0, 1'h1, 2'h0, s1, s0}, "status");
        end
    endtask

    task automatic t_prelatch;
        logic [1:0] r;
        do_reset(3'h1, 4'h8);
        axi_write(A_LINK, 8'h00, 4'hF, r);
        check(32'(strap_done), 32'h0, "write before latch");
        wait_done();
        check(32'(cable_type_select_link_enable), 32'h0, "write wins");
        check(32'(outside_control_enable), 32'h1, "strap kept");
    endtask

    task automatic t_ignore;
        logic [1:0]  r;
        logic [31:0] d;
        sel0_row <= 3'h4;
        sel1_row <= 4'h1;
        repeat (30) @(posedge aclk);
        check({display_id_local, aux_audio_enable, outside_control_enable,
               far_display_id_copy}, 4'h3, "late strap");
        axi_read(A_STAT, d, r);
        check(d, 32'h83, "status follows pins");
    endtask

    task automatic t_override;
        logic [1:0]  r;
        logic [31:0] d;
        axi_write(A_CFG, 8'h22, 4'hF, r);
        check({outside_control_enable, far_display_id_copy,
               aux_audio_enable}, 3'h3, "cfg write");
        axi_read(A_CFG, d, r);
        check(d, 32'h22, "cfg readback");
        axi_write(A_CTL, 8'h01, 4'hF, r);
        check(32'(display_id_local), 32'h1, "ctl write");
        axi_write(A_CTL, 8'h00, 4'h0, r);
        check(32'(display_id_local), 32'h1, "strobe off");
        axi_read(A_FAR, d, r);
        check(d, 32'hA0, "far addr reset");
        axi_write(A_FAR, 8'hB4, 4'hF, r);
        check(32'(far_display_id_addr), 32'hB4, "far addr write");
        axi_write(A_STAT, 8'h00, 4'hF, r);
        check(32'(r), 32'(RESP_OKAY), "status write resp");
        axi_read(A_STAT, d, r);
        check(d, 32'h83, "status read only");
    endtask

    task automatic t_unmapped;
        logic [1:0]  r;
        logic [31:0] d;
        axi_write(12'h000, 8'hFF, 4'hF, r);
        check(32'(r), 32'(RESP_SLVERR), "unmapped write");
        axi_write(A_CTL + 12'h1, 8'h00, 4'hF, r);
        check(32'(r), 32'(RESP_SLVERR), "misaligned write");
        check(32'(display_id_local), 32'h1, "no side effect");
        axi_read(12'h004, d, r);
        check(d, 32'h0, "unmapped rdata");
        check(32'(r), 32'(RESP_SLVERR), "unmapped read");
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end

    initial begin
        #100000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        n_errors = 0;
        total_checks = 0;
        aresetn = 1'h0;
        sel0_row = 3'h1;
        sel1_row = 4'h1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_bready, s_axi_rready} = 2'h3;
        s_axi_awaddr = 12'h0;
        s_axi_araddr = 12'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        t_straps();
        t_prelatch();
        t_ignore();
        t_override();
        t_unmapped();
        final_report();
    end
endmodule // testbench
`default_nettype wire
